/* hw/tcp_defs.vh */
// Constants for the timer compare, one-pulse and PWM block.
`ifndef TCP_DEFS_VH
`define TCP_DEFS_VH
`define TCP_CNT_RESET 16'hFFFC
`define TCP_CAP_ONE_PULSE 16'hFFFD
`define TCP_CMP_RESET 16'h8000
`define TCP_CMP_LATE 16'h0001
`define TCP_PRE_DIV4 2'h0
`define TCP_PRE_DIV8 2'h1
`define TCP_PRE_DIV2 2'h2
`define TCP_PRE_EXT 2'h3
`define TCP_DIV2_LAST 3'h1
`define TCP_DIV4_LAST 3'h3
`define TCP_DIV8_LAST 3'h7
`endif

/* hw/tcp_prescaler.v */
// Timer clock enable: divided core clock or edge of an external clock input.
`timescale 1ns/1ps
`default_nettype none
`include "tcp_defs.vh"
module tcp_prescaler (
  input wire core_clk,
  input wire sys_rst,
  input wire [1:0] timer_prescale_select,
  input wire ext_clk_in,
  input wire ext_clk_rising,
  output reg timer_tick_q
);
  reg [2:0] div_q;
  reg ext_prev_q;
  reg [2:0] last;
  wire ext_edge;

  assign ext_edge = ext_clk_rising ? (ext_clk_in & ~ext_prev_q) : (~ext_clk_in & ext_prev_q);

  always @* begin
    case (timer_prescale_select)
      `TCP_PRE_DIV2: last = `TCP_DIV2_LAST;
      `TCP_PRE_DIV8: last = `TCP_DIV8_LAST;
      default: last = `TCP_DIV4_LAST;
    endcase
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= 3'h0;
      ext_prev_q <= 1'b0;
      timer_tick_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_clk_in;
      if (div_q >= last) begin
        div_q <= 3'h0;
      end else begin
        div_q <= div_q + 3'h1;
      end
      if (timer_prescale_select == `TCP_PRE_EXT) begin
        timer_tick_q <= ext_edge;
      end else begin
        timer_tick_q <= (div_q >= last);
      end
    end
  end
endmodule
`default_nettype wire

/* hw/tcp_timer.v */
// Output compare, one-pulse and PWM section of a 16-bit free-running timer.
//
// Behaviour
// RQ1: A compare match sets its flag and, if pin enabled, drives its level.
// RQ2: Compare flags raise the interrupt only with enable set and CPU mask clear.
// RQ3: Compare pin latches are low during reset.
// RQ4: A flag clears after a status read while set, then a low-byte access.
// RQ5: A high-byte compare write blocks matches until the low byte is written.
// RQ6: The low-byte write re-enables compare and clears a pending flag.
// RQ7: With pin output disabled, flag and interrupt still work, pin untouched.
// RQ8: Divide-by-two matches at the compare value, other clocks one count later.
// RQ9: Force bit copies the level to an enabled pin, no flag, no interrupt.
// RQ10: Force bits do nothing in one-pulse or PWM mode.
// RQ11: One-pulse trigger edge loads counter, starts pulse, sets capture flag, value.
// RQ12: The one-pulse capture flag raises the interrupt with capture enable set.
// RQ13: One-pulse match on compare one ends the pulse with the after level.
// RQ14: One-pulse mode never sets compare flag one; compare two still works.
// RQ15: With both mode bits set only PWM mode operates.
// RQ16: One-pulse capture pin one captures nothing; pin two still captures.
// RQ17: One-pulse compare two flags time but drives no waveform.
// RQ18: PWM compare two match reloads the counter, setting the period.
// RQ19: PWM pin takes after level on compare one, pulse level on compare two.
// RQ20: PWM mode sets neither compare flag.
// RQ21: PWM compare two match sets capture flag one, which may interrupt.
// RQ22: PWM mode disconnects capture pin one; pin two still captures.
// RQ23: Compare registers reset to 8000h and are never changed by hardware.
// RQ24: Counter resets to FFFCh and a low-byte write reloads FFFCh.
`timescale 1ns/1ps
`default_nettype none
`include "tcp_defs.vh"
module tcp_timer (
  input wire core_clk,
  input wire sys_rst,
  input wire cpu_irq_mask,
  input wire [7:0] wr_data,
  input wire [1:0] cmp_high_wr,
  input wire [1:0] cmp_low_wr,
  input wire [1:0] cmp_low_rd,
  input wire [1:0] cap_low_rd,
  input wire status_rd,
  input wire cnt_low_wr,
  input wire capture_irq_enable,
  input wire compare_irq_enable,
  input wire [1:0] force_compare_bit,
  input wire level_after_pulse,
  input wire level_during_pulse,
  input wire capture_edge_one,
  input wire capture_edge_two,
  input wire [1:0] compare_pin_enable,
  input wire single_pulse_select,
  input wire pwm_select,
  input wire [1:0] timer_prescale_select,
  input wire ext_clk_in,
  input wire ext_clk_rising,
  input wire capture_pin_one,
  input wire capture_pin_two,
  output reg [1:0] compare_output_pin,
  output reg [1:0] compare_output_oe,
  output reg [1:0] compare_match_flag,
  output reg capture_flag_one,
  output reg capture_flag_two,
  output reg timer_irq,
  output reg [15:0] counter_value,
  output reg [15:0] compare_value_one,
  output reg [15:0] compare_value_two,
  output reg [15:0] capture_value_one,
  output reg [15:0] capture_value_two
);
  wire timer_tick;
  reg cnt_new_q;
  reg [1:0] inhibit_q;
  reg [1:0] cmp_armed_q;
  reg [1:0] cap_armed_q;
  reg cap1_prev_q;
  reg cap2_prev_q;
  wire pwm_mode;
  wire pulse_mode;
  wire normal_mode;
  wire late_match;
  wire [1:0] match;
  wire cap1_edge;
  wire cap2_edge;
  wire [1:0] level;

  // Matches are evaluated once per new counter value so a slow timer clock gives one event.
  function cmp_hit;
    input [15:0] cnt;
    input [15:0] cmp;
    input late;
    begin
      cmp_hit = (cnt == (late ? cmp + `TCP_CMP_LATE : cmp));
    end
  endfunction

  function edge_seen;
    input now;
    input prev;
    input rising;
    begin
      edge_seen = rising ? (now & ~prev) : (~now & prev);
    end
  endfunction

  tcp_prescaler u_pre (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .timer_prescale_select(timer_prescale_select),
    .ext_clk_in(ext_clk_in),
    .ext_clk_rising(ext_clk_rising),
    .timer_tick_q(timer_tick)
  );

  assign pwm_mode = pwm_select; // RQ15
  assign pulse_mode = single_pulse_select & ~pwm_select; // RQ15
  assign normal_mode = ~single_pulse_select & ~pwm_select;
  assign late_match = (timer_prescale_select != `TCP_PRE_DIV2); // RQ8
  assign level = {level_during_pulse, level_after_pulse};
  assign match[0] = cnt_new_q & ~inhibit_q[0] & cmp_hit(counter_value, compare_value_one, late_match); // RQ5 RQ8
  assign match[1] = cnt_new_q & ~inhibit_q[1] & cmp_hit(counter_value, compare_value_two, late_match); // RQ5 RQ8
  assign cap1_edge = edge_seen(capture_pin_one, cap1_prev_q, capture_edge_one);
  assign cap2_edge = edge_seen(capture_pin_two, cap2_prev_q, capture_edge_two);

  // Counter and the edge history.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      counter_value <= `TCP_CNT_RESET; // RQ24
      cnt_new_q <= 1'b0;
      cap1_prev_q <= 1'b0;
      cap2_prev_q <= 1'b0;
    end else begin
      cap1_prev_q <= capture_pin_one;
      cap2_prev_q <= capture_pin_two;
      if (cnt_low_wr) begin
        counter_value <= `TCP_CNT_RESET; // RQ24
        cnt_new_q <= 1'b1;
      end else if (pulse_mode & cap1_edge) begin
        counter_value <= `TCP_CNT_RESET; // RQ11 RQ16
        cnt_new_q <= 1'b1;
      end else if (pwm_mode & match[1]) begin
        counter_value <= `TCP_CNT_RESET; // RQ18
        cnt_new_q <= 1'b1;
      end else if (timer_tick) begin
        counter_value <= counter_value + 16'h0001;
        cnt_new_q <= 1'b1;
      end else begin
        cnt_new_q <= 1'b0;
      end
    end
  end

  // Compare registers; only software writes them.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      compare_value_one <= `TCP_CMP_RESET; // RQ23
      compare_value_two <= `TCP_CMP_RESET; // RQ23
      inhibit_q <= 2'h0;
    end else begin
      if (cmp_high_wr[0]) begin
        compare_value_one[15:8] <= wr_data;
      end
      if (cmp_low_wr[0]) begin
        compare_value_one[7:0] <= wr_data;
      end
      if (cmp_high_wr[1]) begin
        compare_value_two[15:8] <= wr_data;
      end
      if (cmp_low_wr[1]) begin
        compare_value_two[7:0] <= wr_data;
      end
      inhibit_q <= (inhibit_q | cmp_high_wr) & ~cmp_low_wr; // RQ5 RQ6
    end
  end

  // Compare and capture flags; a set in the clearing cycle wins.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      compare_match_flag <= 2'h0;
      cmp_armed_q <= 2'h0;
      capture_flag_one <= 1'b0;
      capture_flag_two <= 1'b0;
      cap_armed_q <= 2'h0;
      capture_value_one <= 16'h0000;
      capture_value_two <= 16'h0000;
    end else begin
      if (status_rd) begin
        cmp_armed_q <= cmp_armed_q | compare_match_flag; // RQ4
        cap_armed_q <= cap_armed_q | {capture_flag_two, capture_flag_one};
      end else begin
        cmp_armed_q <= cmp_armed_q & ~(cmp_low_wr | cmp_low_rd);
        cap_armed_q <= cap_armed_q & ~cap_low_rd;
      end
      // Flag one: normal mode only; flag two: not in PWM.
      if (match[0] & normal_mode) begin
        compare_match_flag[0] <= 1'b1; // RQ1 RQ7 RQ14 RQ20
      end else if (cmp_armed_q[0] & (cmp_low_wr[0] | cmp_low_rd[0])) begin
        compare_match_flag[0] <= 1'b0; // RQ4 RQ6
      end
      if (match[1] & ~pwm_mode) begin
        compare_match_flag[1] <= 1'b1; // RQ1 RQ14 RQ17 RQ20
      end else if (cmp_armed_q[1] & (cmp_low_wr[1] | cmp_low_rd[1])) begin
        compare_match_flag[1] <= 1'b0; // RQ4 RQ6
      end
      if (pulse_mode & cap1_edge) begin
        capture_flag_one <= 1'b1; // RQ11
        capture_value_one <= `TCP_CAP_ONE_PULSE; // RQ11
      end else if (pwm_mode & match[1]) begin
        capture_flag_one <= 1'b1; // RQ21
      end else if (normal_mode & cap1_edge) begin
        capture_flag_one <= 1'b1; // RQ16 RQ22
        capture_value_one <= counter_value;
      end else if (cap_armed_q[0] & cap_low_rd[0]) begin
        capture_flag_one <= 1'b0;
      end
      if (cap2_edge) begin
        capture_flag_two <= 1'b1; // RQ16 RQ22
        capture_value_two <= counter_value;
      end else if (cap_armed_q[1] & cap_low_rd[1]) begin
        capture_flag_two <= 1'b0;
      end
    end
  end

  // Pin latches; a disabled pin keeps its latch and the port pin stays general I/O.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      compare_output_pin <= 2'h0; // RQ3
      compare_output_oe <= 2'h0;
      timer_irq <= 1'b0;
    end else begin
      compare_output_oe <= compare_pin_enable; // RQ7
      if (compare_pin_enable[0]) begin
        if (pwm_mode) begin
          if (match[1]) begin
            compare_output_pin[0] <= level_during_pulse; // RQ19
          end else if (match[0]) begin
            compare_output_pin[0] <= level_after_pulse; // RQ19
          end
        end else if (pulse_mode) begin
          if (cap1_edge) begin
            compare_output_pin[0] <= level_during_pulse; // RQ11
          end else if (match[0]) begin
            compare_output_pin[0] <= level_after_pulse; // RQ13
          end
        end else if (match[0] | force_compare_bit[0]) begin
          compare_output_pin[0] <= level[0]; // RQ1 RQ9 RQ10
        end
      end
      if (compare_pin_enable[1] & normal_mode & (match[1] | force_compare_bit[1])) begin
        compare_output_pin[1] <= level[1]; // RQ1 RQ9 RQ10 RQ17
      end
      timer_irq <= ~cpu_irq_mask & ((compare_irq_enable & (|compare_match_flag)) |
        (capture_irq_enable & (capture_flag_one | capture_flag_two))); // RQ2 RQ12 RQ21
    end
  end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the timer compare, one-pulse and PWM block.
`timescale 1ns/1ps
`default_nettype none
`include "tcp_defs.vh"
module tb_top;
  logic core_clk, sys_rst, cpu_irq_mask, status_rd, cnt_low_wr, trig, seen_hi, seen_lo;
  logic [7:0] wr_data;
  logic [1:0] cmp_high_wr, cmp_low_wr, cmp_low_rd, cap_low_rd, force_compare_bit, compare_pin_enable;
  logic [1:0] timer_prescale_select, compare_output_pin, compare_match_flag;
  logic capture_irq_enable, compare_irq_enable, level_after_pulse, level_during_pulse, capture_edge_one;
  logic single_pulse_select, pwm_select, capture_pin_one, capture_pin_two, capture_flag_one, timer_irq;
  logic [15:0] counter_value, compare_value_one, capture_value_one;
  int num_errors, samples_checked, cycles, k;
  tcp_timer DUT (.core_clk, .sys_rst, .cpu_irq_mask, .wr_data, .cmp_high_wr, .cmp_low_wr, .cmp_low_rd,
    .cap_low_rd, .status_rd, .cnt_low_wr, .capture_irq_enable, .compare_irq_enable, .force_compare_bit,
    .level_after_pulse, .level_during_pulse, .capture_edge_one, .capture_edge_two(1'h1), .compare_pin_enable,
    .single_pulse_select, .pwm_select, .timer_prescale_select, .ext_clk_in(1'h0), .ext_clk_rising(1'h1),
    .capture_pin_one, .capture_pin_two, .compare_output_pin, .compare_output_oe(), .compare_match_flag,
    .capture_flag_one, .capture_flag_two(), .timer_irq, .counter_value, .compare_value_one,
    .compare_value_two(), .capture_value_one, .capture_value_two());
  tcp_pin_model PM (.core_clk, .trig_one(trig), .capture_pin_one, .capture_pin_two);
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  task complete_run;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      complete_run();
    end
  end
  task cyc;
    @(posedge core_clk);
    #1;
  endtask
  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask
  task cmp_wr(input int i, input logic [15:0] v);
    wr_data = v[15:8];
    cmp_high_wr[i] = 1'h1;
    cyc;
    cmp_high_wr[i] = 1'h0;
    status_rd = 1'h1;
    cyc;
    status_rd = 1'h0;
    wr_data = v[7:0];
    cmp_low_wr[i] = 1'h1;
    cyc;
    cmp_low_wr[i] = 1'h0;
  endtask
  task clr(input logic [1:0] cmp, input logic [1:0] cap);
    status_rd = 1'h1;
    cyc;
    status_rd = 1'h0;
    cmp_low_rd = cmp;
    cap_low_rd = cap;
    cyc;
    {cmp_low_rd, cap_low_rd} = 4'h0;
  endtask
  initial begin
    {cpu_irq_mask, status_rd, cnt_low_wr, trig, wr_data, cmp_high_wr, cmp_low_wr, cmp_low_rd} = 16'h0000;
    {cap_low_rd, force_compare_bit, single_pulse_select, pwm_select, level_during_pulse} = 7'h00;
    {capture_irq_enable, compare_irq_enable, level_after_pulse, capture_edge_one} = 4'hF;
    compare_pin_enable = 2'h1;
    timer_prescale_select = `TCP_PRE_DIV2;
    sys_rst = 1'h1;
    repeat (4) cyc;
    chk("reset pins", 16'h0000, 16'(compare_output_pin));
    chk("reset counter", `TCP_CNT_RESET, counter_value);
    chk("reset compare", `TCP_CMP_RESET, compare_value_one);
    sys_rst = 1'h0;
    cyc;
    cmp_wr(0, 16'h0010);
    cmp_wr(1, 16'h0030);
    for (k = 0; k < 200 && compare_match_flag[0] !== 1'h1; k++) cyc;
    chk("match count div2", 16'h0010, counter_value);
    chk("match pin", 16'h0001, 16'(compare_output_pin));
    cyc;
    chk("match irq", 16'h0001, 16'(timer_irq));
    cmp_wr(0, 16'h0200);
    chk("flag after rewrite", 16'h0000, 16'(compare_match_flag));
    timer_prescale_select = `TCP_PRE_DIV4;
    for (k = 0; k < 400 && compare_match_flag[1] !== 1'h1; k++) cyc;
    chk("match count div4", 16'h0031, counter_value);
    chk("disabled pin", 16'h0001, 16'(compare_output_pin));
    cpu_irq_mask = 1'h1;
    repeat (2) cyc;
    chk("masked irq", 16'h0000, 16'(timer_irq));
    cpu_irq_mask = 1'h0;
    clr(2'h2, 2'h0);
    chk("flag clear", 16'h0000, 16'(compare_match_flag));
    {level_after_pulse, force_compare_bit} = 3'h1;
    repeat (3) cyc;
    chk("forced pin", 16'h0000, 16'(compare_output_pin));
    chk("forced flags", 16'h0000, 16'(compare_match_flag));
    {single_pulse_select, level_during_pulse, level_after_pulse} = 3'h7;
    repeat (3) cyc;
    chk("force in pulse mode", 16'h0000, 16'(compare_output_pin));
    {force_compare_bit, level_after_pulse} = 3'h0;
    cmp_wr(0, 16'h0020);
    trig = 1'h1;
    cyc;
    trig = 1'h0;
    for (k = 0; k < 50 && capture_flag_one !== 1'h1; k++) cyc;
    chk("pulse capture", 16'hFFFD, capture_value_one);
    cyc;
    chk("pulse start", 16'h0001, 16'(compare_output_pin));
    chk("pulse irq", 16'h0001, 16'(timer_irq));
    for (k = 0; k < 300 && compare_output_pin[0] !== 1'h0; k++) cyc;
    chk("pulse end count", 16'h0021, counter_value);
    chk("pulse flag one", 16'h0000, 16'(compare_match_flag[0]));
    pwm_select = 1'h1;
    timer_prescale_select = `TCP_PRE_DIV8;
    clr(2'h0, 2'h1);
    cmp_wr(1, 16'h0040);
    cnt_low_wr = 1'h1;
    cyc;
    cnt_low_wr = 1'h0;
    chk("counter reload", `TCP_CNT_RESET, counter_value);
    // A trigger in PWM mode must neither capture nor restart the period.
    trig = 1'h1;
    cyc;
    trig = 1'h0;
    {seen_hi, seen_lo} = 2'h0;
    for (k = 0; k < 800; k++) begin
      cyc;
      if (compare_output_pin[0] === 1'h1) seen_hi = 1'h1;
      if (compare_output_pin[0] === 1'h0) seen_lo = 1'h1;
      if (counter_value > 16'h0041 && counter_value < 16'hFFFC) chk("pwm period", 16'h0041, counter_value);
    end
    chk("pwm levels", 16'h0003, 16'({seen_hi, seen_lo}));
    chk("pwm period flag", 16'h0001, 16'(capture_flag_one));
    chk("pwm capture one ignored", 16'hFFFD, capture_value_one);
    complete_run();
  end
endmodule
`default_nettype wire

/* testbench/tcp_pin_model.sv */
// Far-side driver of the capture pins: each request gives one clean high pulse.
`timescale 1ns/1ps
`default_nettype none
module tcp_pin_model (
  input wire logic core_clk,
  input wire logic trig_one,
  output wire logic capture_pin_one,
  output wire logic capture_pin_two
);
  logic [3:0] sh_q;
  initial sh_q = 4'h0;
  // The pulse lasts four core cycles, one for each bit of sh_q.
  always @(posedge core_clk) sh_q <= #1 {sh_q[2:0], trig_one};
  assign capture_pin_one = |sh_q;
  assign capture_pin_two = 1'h0;
endmodule
`default_nettype wire

/* testbench/tcp_timer_asserts.sv */
// Port checker for the timer compare, one-pulse and PWM block.
`timescale 1ns/1ps
`default_nettype none
module tcp_timer_chk (
  input wire core_clk,
  input wire sys_rst,
  input wire cpu_irq_mask,
  input wire [1:0] cmp_high_wr,
  input wire [1:0] cmp_low_wr,
  input wire status_rd,
  input wire single_pulse_select,
  input wire pwm_select,
  input wire [1:0] compare_output_pin,
  input wire [1:0] compare_match_flag,
  input wire capture_flag_one,
  input wire timer_irq,
  input wire [15:0] compare_value_one,
  input wire [15:0] capture_value_one
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Tracks an open high/low write pair so the match inhibit can be judged.
  reg inh_q;
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) inh_q <= 1'h0;
    else if (cmp_low_wr[0]) inh_q <= 1'h0;
    else if (cmp_high_wr[0]) inh_q <= 1'h1;
  end
  a_reset_pins_low: assert property (disable iff (1'h0) sys_rst |-> compare_output_pin == 2'h0)
    else $error("compare pins not low in reset");
  a_flag_one_mode: assert property ($rose(compare_match_flag[0]) |-> !$past(pwm_select) && !$past(single_pulse_select))
    else $error("compare flag one set in pulse or pwm mode");
  a_flag_two_pwm: assert property ($rose(compare_match_flag[1]) |-> !$past(pwm_select))
    else $error("compare flag two set in pwm mode");
  a_irq_masked_off: assert property (cpu_irq_mask && $past(cpu_irq_mask) |-> !timer_irq)
    else $error("interrupt raised while masked");
  a_high_inhibit: assert property (inh_q && $past(inh_q) |-> !$rose(compare_match_flag[0]))
    else $error("match not inhibited after high write");
  a_low_clears: assert property (inh_q && status_rd && compare_match_flag[0] ##1 cmp_low_wr[0] |=> !compare_match_flag[0])
    else $error("low write did not clear flag");
  a_cmp_stable: assert property (!cmp_high_wr[0] && !cmp_low_wr[0] |=> $stable(compare_value_one))
    else $error("compare register changed without write");
  a_pulse_capture: assert property ($rose(capture_flag_one) && $past(single_pulse_select) && !$past(pwm_select)
    |-> capture_value_one == 16'hFFFD)
    else $error("pulse trigger capture value wrong");
  c_flag_one: cover property ($rose(compare_match_flag[0]));
  c_pulse: cover property ($rose(capture_flag_one) && single_pulse_select);
  c_pwm_pin: cover property (pwm_select && $rose(compare_output_pin[0]));
endmodule
bind tcp_timer tcp_timer_chk u_chk (.core_clk, .sys_rst, .cpu_irq_mask, .cmp_high_wr, .cmp_low_wr, .status_rd,
  .single_pulse_select, .pwm_select, .compare_output_pin, .compare_match_flag, .capture_flag_one, .timer_irq,
  .compare_value_one, .capture_value_one);
`default_nettype wire
